// file: common/pcr_pkg.sv
/*
 * Constants for the power, clock-gating and clear-line control block:
 * register addresses, field positions and reset values.
 * Assumes a host chip-select bus that presents full byte addresses.
 */
package pcr_pkg;
    // Register byte addresses
    localparam logic [31:0] PCR_ADDR_POWER  = 32'h1080_7000;
    localparam logic [31:0] PCR_ADDR_CLOCK  = 32'h1080_7004;
    localparam logic [31:0] PCR_ADDR_ROM    = 32'h1080_7008;
    localparam logic [31:0] PCR_ADDR_INEN   = 32'h1080_700c;
    localparam logic [31:0] PCR_ADDR_CLEAR  = 32'h1080_7010;

    // Power control fields
    localparam int PCR_PWR_DISPLAY   = 0;
    localparam int PCR_PWR_PANEL     = 1;
    localparam int PCR_PWR_BACKLIGHT = 2;
    localparam int PCR_PWR_IOBUS     = 3;
    localparam int PCR_PWR_SPARE_LO  = 4;
    localparam int PCR_PWR_SPARE_HI  = 6;
    localparam int PCR_PWR_RSVD      = 7;
    localparam int PCR_PWR_PANEL_OE  = 8;
    localparam int PCR_PWR_IOBUS_OE  = 9;
    localparam int PCR_PWR_USB_OE    = 10;
    localparam int PCR_PWR_WIDTH     = 11;

    // Clock control fields
    localparam int PCR_CLK_CARD1     = 0;
    localparam int PCR_CLK_CARD2     = 1;
    localparam int PCR_CLK_FLASH     = 2;
    localparam int PCR_CLK_IOBUS     = 3;
    localparam int PCR_CLK_USB_GATE  = 4;
    localparam int PCR_CLK_USB_FORCE = 5;
    localparam int PCR_CLK_WIDTH     = 6;

    // Boot ROM control fields
    localparam int PCR_ROM_ADDR_ALL  = 0;
    localparam int PCR_ROM_SIZE_LO   = 1;
    localparam int PCR_ROM_SIZE_HI   = 2;
    localparam int PCR_ROM_WIDTH     = 3;

    // Input enable and clear fields
    localparam int PCR_INEN_CS       = 0;
    localparam int PCR_CLR_LOW       = 0;
    localparam int PCR_CLR_HIGH      = 1;
    localparam int PCR_CLR_WIDTH     = 2;

    // Reset values
    localparam logic [PCR_PWR_WIDTH-1:0] PCR_RST_POWER = 11'h000;
    localparam logic [PCR_CLK_WIDTH-1:0] PCR_RST_CLOCK = 6'h00;
    localparam logic [PCR_ROM_WIDTH-1:0] PCR_RST_ROM   = 3'h0;
    localparam logic                     PCR_RST_INEN  = 1'b0;
    localparam logic [PCR_CLR_WIDTH-1:0] PCR_RST_CLEAR = 2'h0;

    // Decoded boot ROM size per chip select
    typedef enum logic [1:0] {
        PCR_ROM_8MB,
        PCR_ROM_4MB,
        PCR_ROM_16MB
    } pcr_rom_size_t;

    // Bus access sequencer
    typedef enum {
        PCR_BUS_IDLE,
        PCR_BUS_HOLD
    } pcr_bus_state_t;
endpackage

// file: rtl/pcr_clock_gate.sv
/*
 * Glitch-free clock gate: enable latched while the clock is low.
 * Assumes enable comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pcr_clock_gate (
    input  wire logic clk_in,
    input  wire logic enable,
    output logic      clk_out
);
    logic enable_latch;

    // Latch transparent on low phase avoids runt pulses
    always_latch begin
        if (!clk_in) begin
            enable_latch <= enable;
        end
    end

    assign clk_out = clk_in & enable_latch;
endmodule
`default_nettype wire

// file: rtl/pcr_power_control.sv
/*
 * Power, clock-gating, boot ROM address and clear-line control registers.
 * Assumes the host chip-select bus is already synchronous to clk_sys;
 * asynchronous I/O-bus input pins are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Display-on pin follows the display-on bit; 1 means on.
// RULE2: Active-low panel power-off pin is the inverted panel power bit.
// RULE3: Active-low backlight-off pin is the inverted backlight bit.
// RULE4: I/O-bus module power pin follows its stored bit.
// RULE5: Three spare power pins follow power register bits 6 to 4.
// RULE6: Bit 7 is reserved storage, read back as written, no effect.
// RULE7: Panel output enable 0 forces all panel outputs low.
// RULE8: I/O-bus enable 0 drives bus outputs low and blocks inputs.
// RULE9: USB output enable 0 forces port power output to 0.
// RULE10: Power-on reset clears all five registers to 0.
// RULE11: Software clears bus enable and module power before bus power-off.
// RULE12: Software switches off unneeded supplies before suspend.
// RULE13: Card 1, card 2 and flash card clocks gated by own bits.
// RULE14: I/O-bus clock on demand when bit is 0, always when 1.
// RULE15: USB clock stops at gate 0; force bit picks always or adaptive.
// RULE16: Software should use USB gate 1 with force left 0.
// RULE17: ROM address output only on ROM access unless always-out bit set.
// RULE18: Software sets always-out only with a debug board attached.
// RULE19: ROM size decodes 00 8MB, 01 4MB, 1x 16MB.
// RULE20: Chip-select inputs ignored until host chip-select enable is 1; a write to the enable register itself is still taken.
// RULE21: Low clear pin is bit 0; high clear pin is inverse of bit 1.
module pcr_power_control
    import pcr_pkg::*;
#(
    parameter int PANEL_WIDTH = 24,
    parameter int IOBUS_WIDTH = 16,
    parameter int ROM_ADDR_W  = 24
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    // Host chip-select register port
    input  wire logic                   host_memory_chip_select,
    input  wire logic                   host_write,
    input  wire logic [31:0]            host_addr,
    input  wire logic [31:0]            host_wdata,
    output logic      [31:0]            host_rdata,
    output logic                        host_ack,
    // Power pins
    output logic                        panel_display_on,
    output logic                        panel_power_off_n,
    output logic                        backlight_off_n,
    output logic                        iobus_module_power,
    output logic      [2:0]             spare_power_pins,
    // Panel, I/O-bus and USB output gating
    input  wire logic [PANEL_WIDTH-1:0] panel_data_core,
    output logic      [PANEL_WIDTH-1:0] panel_data_pin,
    input  wire logic [IOBUS_WIDTH-1:0] iobus_out_core,
    output logic      [IOBUS_WIDTH-1:0] iobus_out_pin,
    input  wire logic [IOBUS_WIDTH-1:0] iobus_in_pin,
    output logic      [IOBUS_WIDTH-1:0] iobus_in_core,
    input  wire logic                   usb_port_power_core,
    output logic                        usb_port_power_out,
    // Clock gating
    input  wire logic                   iobus_clock_request,
    input  wire logic                   usb_clock_request,
    output logic                        card1_clk,
    output logic                        card2_clk,
    output logic                        flash_clk,
    output logic                        iobus_clk,
    output logic                        usb_clk,
    // Boot ROM interface
    input  wire logic                   rom_access,
    input  wire logic [ROM_ADDR_W-1:0]  rom_addr_core,
    output logic      [ROM_ADDR_W-1:0]  rom_addr_pin,
    output logic      [1:0]             rom_size_code,
    // Clear lines
    output logic                        iobus_clear_low_pin,
    output logic                        iobus_clear_high_pin
);
    logic [PCR_PWR_WIDTH-1:0] power_reg;
    logic [PCR_PWR_WIDTH-1:0] power_next;
    logic [PCR_CLK_WIDTH-1:0] clock_reg;
    logic [PCR_CLK_WIDTH-1:0] clock_next;
    logic [PCR_ROM_WIDTH-1:0] rom_reg;
    logic [PCR_ROM_WIDTH-1:0] rom_next;
    logic                     inen_reg;
    logic                     inen_next;
    logic [PCR_CLR_WIDTH-1:0] clear_reg;
    logic [PCR_CLR_WIDTH-1:0] clear_next;
    logic [IOBUS_WIDTH-1:0]   iobus_meta_reg;
    logic [IOBUS_WIDTH-1:0]   iobus_sync_reg;
    logic [31:0]              rdata_next;
    logic                     ack_next;
    pcr_bus_state_t           bus_state_reg;
    pcr_bus_state_t           bus_state_next;
    pcr_rom_size_t            rom_size;

    // Chip-select honoured only once software enabled it [RULE20]
    wire cs_live  = host_memory_chip_select & inen_reg;
    wire access   = cs_live & (bus_state_reg == PCR_BUS_IDLE);
    wire wr_en    = access & host_write;
    wire hit_pwr  = host_addr == PCR_ADDR_POWER;
    wire hit_clk  = host_addr == PCR_ADDR_CLOCK;
    wire hit_rom  = host_addr == PCR_ADDR_ROM;
    wire hit_inen = host_addr == PCR_ADDR_INEN;
    wire hit_clr  = host_addr == PCR_ADDR_CLEAR;

    // Write data selection; bit 7 stored as plain read/write storage [RULE6]
    assign power_next = (wr_en & hit_pwr) ? host_wdata[PCR_PWR_WIDTH-1:0] : power_reg;
    assign clock_next = (wr_en & hit_clk) ? host_wdata[PCR_CLK_WIDTH-1:0] : clock_reg;
    assign rom_next   = (wr_en & hit_rom) ? host_wdata[PCR_ROM_WIDTH-1:0] : rom_reg;
    assign inen_next  = (host_memory_chip_select & host_write & hit_inen
                         & (bus_state_reg == PCR_BUS_IDLE)) ? host_wdata[PCR_INEN_CS] : inen_reg;
    assign clear_next = (wr_en & hit_clr) ? host_wdata[PCR_CLR_WIDTH-1:0] : clear_reg;

    // Read mux; unmapped addresses read zero
    assign rdata_next = !(access & !host_write) ? 32'h0000_0000 :
                        hit_pwr  ? {21'h0, power_reg} :
                        hit_clk  ? {26'h0, clock_reg} :
                        hit_rom  ? {29'h0, rom_reg} :
                        hit_inen ? {31'h0, inen_reg} :
                        hit_clr  ? {30'h0, clear_reg} : 32'h0000_0000;

    // One-cycle ack, then wait for chip-select release before next access
    assign ack_next       = access;
    assign bus_state_next = access ? PCR_BUS_HOLD :
                            (!host_memory_chip_select ? PCR_BUS_IDLE : bus_state_reg);

    // Write enable for the chip-select enable itself bypasses the gate,
    // otherwise software could never open the interface.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            power_reg     <= PCR_RST_POWER; // [RULE10]
            clock_reg     <= PCR_RST_CLOCK; // [RULE10]
            rom_reg       <= PCR_RST_ROM;   // [RULE10]
            inen_reg      <= PCR_RST_INEN;  // [RULE10]
            clear_reg     <= PCR_RST_CLEAR; // [RULE10]
            bus_state_reg <= PCR_BUS_IDLE;
            host_rdata    <= 32'h0000_0000;
            host_ack      <= 1'b0;
        end else begin
            power_reg     <= power_next;
            clock_reg     <= clock_next;
            rom_reg       <= rom_next;
            inen_reg      <= inen_next;
            clear_reg     <= clear_next;
            bus_state_reg <= bus_state_next;
            host_rdata    <= rdata_next;
            host_ack      <= ack_next;
        end
    end

    // Two-stage synchroniser on I/O-bus input pins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            iobus_meta_reg <= '0;
            iobus_sync_reg <= '0;
        end else begin
            iobus_meta_reg <= iobus_in_pin;
            iobus_sync_reg <= iobus_meta_reg;
        end
    end

    // Boot ROM size decode, low bit ignored when high bit set [RULE19]
    assign rom_size = rom_reg[PCR_ROM_SIZE_HI] ? PCR_ROM_16MB :
                      (rom_reg[PCR_ROM_SIZE_LO] ? PCR_ROM_4MB : PCR_ROM_8MB);

    // Pin-level next values
    wire                   pwr_usb_oe   = power_reg[PCR_PWR_USB_OE];
    wire                   pwr_iobus_oe = power_reg[PCR_PWR_IOBUS_OE];
    wire                   pwr_panel_oe = power_reg[PCR_PWR_PANEL_OE];
    wire [ROM_ADDR_W-1:0]  rom_addr_next =
        (rom_reg[PCR_ROM_ADDR_ALL] | rom_access) ? rom_addr_core : '0; // [RULE17]

    // All pin outputs except the gated clocks registered; one cycle behind the register file
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            panel_display_on     <= 1'b0;
            panel_power_off_n    <= 1'b1;
            backlight_off_n      <= 1'b1;
            iobus_module_power   <= 1'b0;
            spare_power_pins     <= 3'h0;
            panel_data_pin       <= '0;
            iobus_out_pin        <= '0;
            iobus_in_core        <= '0;
            usb_port_power_out   <= 1'b0;
            rom_addr_pin         <= '0;
            rom_size_code        <= 2'h0;
            iobus_clear_low_pin  <= 1'b0;
            iobus_clear_high_pin <= 1'b1;
        end else begin
            panel_display_on     <= power_reg[PCR_PWR_DISPLAY];                    // [RULE1]
            panel_power_off_n    <= ~power_reg[PCR_PWR_PANEL];                     // [RULE2]
            backlight_off_n      <= ~power_reg[PCR_PWR_BACKLIGHT];                 // [RULE3]
            iobus_module_power   <= power_reg[PCR_PWR_IOBUS];                      // [RULE4]
            spare_power_pins     <= power_reg[PCR_PWR_SPARE_HI:PCR_PWR_SPARE_LO];  // [RULE5]
            panel_data_pin       <= pwr_panel_oe ? panel_data_core : '0;           // [RULE7]
            iobus_out_pin        <= pwr_iobus_oe ? iobus_out_core : '0;            // [RULE8]
            iobus_in_core        <= pwr_iobus_oe ? iobus_sync_reg : '0;            // [RULE8]
            usb_port_power_out   <= pwr_usb_oe & usb_port_power_core;              // [RULE9]
            rom_addr_pin         <= rom_addr_next;
            rom_size_code        <= rom_size;
            iobus_clear_low_pin  <= clear_reg[PCR_CLR_LOW];                        // [RULE21]
            iobus_clear_high_pin <= ~clear_reg[PCR_CLR_HIGH];                      // [RULE21]
        end
    end

    // Clock enables; adaptive modes follow the controllers' own requests
    wire en_card1 = clock_reg[PCR_CLK_CARD1];                             // [RULE13]
    wire en_card2 = clock_reg[PCR_CLK_CARD2];                             // [RULE13]
    wire en_flash = clock_reg[PCR_CLK_FLASH];                             // [RULE13]
    wire en_iobus = clock_reg[PCR_CLK_IOBUS] | iobus_clock_request;       // [RULE14]
    wire en_usb   = clock_reg[PCR_CLK_USB_GATE]
                    & (clock_reg[PCR_CLK_USB_FORCE] | usb_clock_request); // [RULE15]
    wire [4:0] gate_en = {en_usb, en_iobus, en_flash, en_card2, en_card1};
    wire [4:0] gate_clk;

    // Gated clocks are not registered outputs: a flop cannot carry a clock
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_gate
            pcr_clock_gate u_gate (
                .clk_in  (clk_sys),
                .enable  (gate_en[gi]),
                .clk_out (gate_clk[gi])
            );
        end
    endgenerate
    assign {usb_clk, iobus_clk, flash_clk, card2_clk, card1_clk} = gate_clk;

    // Assertions; pin checks look one cycle back since every pin except the gated clocks is registered
    a_display_pin: assert property (@(posedge clk_sys) disable iff (reset) // [RULE1]
        ##1 panel_display_on == $past(power_reg[PCR_PWR_DISPLAY]))
        else $error("display pin does not follow bit");
    a_panel_power: assert property (@(posedge clk_sys) disable iff (reset) // [RULE2]
        ##1 panel_power_off_n != $past(power_reg[PCR_PWR_PANEL]))
        else $error("panel power pin not inverted");
    a_backlight_pin: assert property (@(posedge clk_sys) disable iff (reset) // [RULE3]
        ##1 backlight_off_n != $past(power_reg[PCR_PWR_BACKLIGHT]))
        else $error("backlight pin not inverted");
    a_iobus_power: assert property (@(posedge clk_sys) disable iff (reset) // [RULE4]
        wr_en && hit_pwr |=> ##1 iobus_module_power == $past(host_wdata[PCR_PWR_IOBUS], 2))
        else $error("module power pin wrong after write");
    a_spare_pins: assert property (@(posedge clk_sys) disable iff (reset) // [RULE5]
        wr_en && hit_pwr |=> ##1
            spare_power_pins == $past(host_wdata[PCR_PWR_SPARE_HI:PCR_PWR_SPARE_LO], 2))
        else $error("spare pins wrong after write");
    // Bit 7 drives nothing, so only its storage can go wrong
    a_reserved_bit: assert property (@(posedge clk_sys) disable iff (reset) // [RULE6]
        wr_en && hit_pwr |=> power_reg[PCR_PWR_RSVD] == $past(host_wdata[PCR_PWR_RSVD]))
        else $error("reserved bit not stored as written");
    a_panel_gate: assert property (@(posedge clk_sys) disable iff (reset) // [RULE7]
        !power_reg[PCR_PWR_PANEL_OE] |=> panel_data_pin == '0)
        else $error("panel outputs not forced low");
    a_iobus_gate: assert property (@(posedge clk_sys) disable iff (reset) // [RULE8]
        !pwr_iobus_oe |=> (iobus_out_pin == '0) && (iobus_in_core == '0))
        else $error("I/O bus not blocked");
    a_usb_power: assert property (@(posedge clk_sys) disable iff (reset) // [RULE9]
        !pwr_usb_oe |=> !usb_port_power_out)
        else $error("USB port power not forced off");
    a_reset_clear: assert property (@(posedge clk_sys) // [RULE10]
        $fell(reset) |-> power_reg == '0 && clock_reg == '0 && rom_reg == '0
            && !inen_reg && clear_reg == '0)
        else $error("registers not cleared by reset");
    // Gated clocks are seen at the falling edge, i.e. in their high phase;
    // that phase carries the enable latched before the rise, hence $past
    a_usb_clock: assert property (@(negedge clk_sys) disable iff (reset) // [RULE15]
        !$past(clock_reg[PCR_CLK_USB_GATE]) |-> !usb_clk)
        else $error("USB clock runs while gated off");
    a_rom_address: assert property (@(posedge clk_sys) disable iff (reset) // [RULE17]
        !rom_reg[PCR_ROM_ADDR_ALL] && !rom_access |=> rom_addr_pin == '0)
        else $error("ROM address driven outside ROM access");
    a_rom_size: assert property (@(posedge clk_sys) disable iff (reset) // [RULE19]
        rom_reg[PCR_ROM_SIZE_HI] |=> rom_size_code == PCR_ROM_16MB)
        else $error("ROM size decode wrong");
    a_cs_ignored: assert property (@(posedge clk_sys) disable iff (reset) // [RULE20]
        !inen_reg |=> !host_ack)
        else $error("access answered while interface disabled");
    a_clear_pins: assert property (@(posedge clk_sys) disable iff (reset) // [RULE21]
        ##1 iobus_clear_high_pin != $past(clear_reg[PCR_CLR_HIGH])
            && iobus_clear_low_pin == $past(clear_reg[PCR_CLR_LOW]))
        else $error("clear pins wrong");
    a_iobus_clk_en: assert property (@(negedge clk_sys) disable iff (reset) // [RULE13] [RULE14]
        $past(clock_reg[PCR_CLK_IOBUS]) |-> iobus_clk
            && (card1_clk == $past(clock_reg[PCR_CLK_CARD1])))
        else $error("clock enable wrong");

    c_enable_cs: cover property (@(posedge clk_sys) disable iff (reset) $rose(inen_reg));
    c_power_write: cover property (@(posedge clk_sys) disable iff (reset) wr_en && hit_pwr);
    c_read_clock: cover property (@(posedge clk_sys) disable iff (reset)
        access && !host_write && hit_clk);
    c_usb_adaptive: cover property (@(posedge clk_sys) disable iff (reset)
        clock_reg[PCR_CLK_USB_GATE] && !clock_reg[PCR_CLK_USB_FORCE]);
endmodule
`default_nettype wire

// file: verif/pcr_host_model.sv
/*
 * Host-side model of the chip-select register bus: single word accesses.
 * Assumes the bench calls its task from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
    input  wire logic        clk_sys,
    input  wire logic        host_ack,
    input  wire logic [31:0] host_rdata,
    output logic             host_memory_chip_select,
    output logic             host_write,
    output logic [31:0]      host_addr,
    output logic [31:0]      host_wdata
);
    // Idle bus from time zero
    initial begin
        host_memory_chip_select = 1'b0;
        host_write = 1'b0;
        host_addr = 32'h0000_0000;
        host_wdata = 32'h0000_0000;
    end

    // Held until ack is sampled; a refused access gives up after six edges
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          output logic got, output logic [31:0] rd);
        int n;
        n = 0;
        got = 1'b0;
        rd = 32'h0000_0000;
        @(negedge clk_sys);
        host_memory_chip_select = 1'b1;
        host_write = wr;
        host_addr = a;
        host_wdata = d;
        while (!got && n < 6) begin
            @(posedge clk_sys);
            n++;
            if (host_ack === 1'b1) begin
                got = 1'b1;
                rd = host_rdata;
            end
        end
        // Released lines flip so a stale value never looks valid
        @(negedge clk_sys);
        host_memory_chip_select = 1'b0;
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
    endtask

    // Opens the chip-select input with one write of 1 to the enable register
    task automatic open_interface(output logic got);
        logic [31:0] rd;
        access(1'b1, 32'h1080_700c, 32'h0000_0001, got, rd);
    endtask
endmodule
`default_nettype wire

// file: verif/power_clock_reset_control_tb_top.sv
/*
 * Self-checking bench for the power control block: register rows, then
 * adaptive clocks, output gating and a mid-run reset.
 * Assumes the host model task is the only bus driver.
 */
`timescale 1ns/1ps
`default_nettype none
module power_clock_reset_control_tb_top
    import pcr_pkg::*;
;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [16:0] pins;
        logic [31:0] rback;
    } pcr_tb_row_t;

    logic clk_sys, reset, cs, wr, ack, got;
    logic [31:0] addr, wdata, rdata, rd;
    logic [23:0] pd_core, pd_pin, ra_core, ra_pin;
    logic [15:0] io_oc, io_op, io_ip, io_ic;
    logic usb_core, usb_out, io_req, usb_req, rom_acc;
    logic disp, off_n, bl_n, iopwr, c1, c2, fl, ioc, usbc, clr_l, clr_h;
    logic [2:0] spare;
    logic [1:0] size;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] addrs [5] = '{PCR_ADDR_POWER, PCR_ADDR_CLOCK, PCR_ADDR_ROM,
                               PCR_ADDR_INEN, PCR_ADDR_CLEAR};
    // Cumulative writes; pins {spare,iopwr,bl_n,off_n,disp,usb,clr_h,clr_l,size,clks}
    pcr_tb_row_t rows [13] = '{
        '{PCR_ADDR_POWER, 32'h0000_0001, 17'h01d00, 32'h0000_0001},
        '{PCR_ADDR_POWER, 32'h0000_00fe, 17'h1e100, 32'h0000_00fe},
        '{PCR_ADDR_POWER, 32'hffff_f700, 17'h01b00, 32'h0000_0700},
        '{PCR_ADDR_CLOCK, 32'h0000_003f, 17'h01b1f, 32'h0000_003f},
        '{PCR_ADDR_CLOCK, 32'h0000_0010, 17'h01b00, 32'h0000_0010},
        '{PCR_ADDR_ROM,   32'h0000_0002, 17'h01b20, 32'h0000_0002},
        '{PCR_ADDR_ROM,   32'h0000_0004, 17'h01b40, 32'h0000_0004},
        '{PCR_ADDR_ROM,   32'h0000_0006, 17'h01b40, 32'h0000_0006},
        '{PCR_ADDR_ROM,   32'h0000_0000, 17'h01b00, 32'h0000_0000},
        '{PCR_ADDR_CLEAR, 32'h0000_0003, 17'h01a80, 32'h0000_0003},
        '{PCR_ADDR_CLEAR, 32'h0000_0000, 17'h01b00, 32'h0000_0000},
        '{32'h1080_7014,  32'h0000_ffff, 17'h01b00, 32'h0000_0000},
        '{PCR_ADDR_POWER, 32'h0000_0000, 17'h01900, 32'h0000_0000}};

    pcr_host_model u_pcr_host_model (.clk_sys(clk_sys), .host_ack(ack), .host_rdata(rdata),
        .host_memory_chip_select(cs), .host_write(wr), .host_addr(addr), .host_wdata(wdata));

    pcr_power_control u_pcr_power_control (.clk_sys(clk_sys), .reset(reset),
        .host_memory_chip_select(cs), .host_write(wr), .host_addr(addr),
        .host_wdata(wdata), .host_rdata(rdata), .host_ack(ack), .panel_display_on(disp),
        .panel_power_off_n(off_n), .backlight_off_n(bl_n), .iobus_module_power(iopwr),
        .spare_power_pins(spare), .panel_data_core(pd_core), .panel_data_pin(pd_pin),
        .iobus_out_core(io_oc), .iobus_out_pin(io_op), .iobus_in_pin(io_ip),
        .iobus_in_core(io_ic), .usb_port_power_core(usb_core), .usb_port_power_out(usb_out),
        .iobus_clock_request(io_req), .usb_clock_request(usb_req), .card1_clk(c1),
        .card2_clk(c2), .flash_clk(fl), .iobus_clk(ioc), .usb_clk(usbc),
        .rom_access(rom_acc), .rom_addr_core(ra_core), .rom_addr_pin(ra_pin),
        .rom_size_code(size), .iobus_clear_low_pin(clr_l), .iobus_clear_high_pin(clr_h));

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] obs();
        return {15'h0, spare, iopwr, bl_n, off_n, disp, usb_out, clr_h, clr_l, size,
                usbc, ioc, fl, c2, c1};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Gated clocks are sampled in the high phase, where they equal their enables
    task automatic settle();
        repeat (4) @(negedge clk_sys);
        @(posedge clk_sys);
        #5;
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard, well beyond the few hundred cycles needed
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        {pd_core, io_oc, io_ip, ra_core} = {24'h5a5a5a, 16'h3c3c, 16'hc3c3, 24'h123456};
        {usb_core, io_req, usb_req, rom_acc} = 4'h8;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        u_pcr_host_model.access(1'b1, PCR_ADDR_POWER, 32'h0000_07ff, got, rd);
        check("refused ack", {31'h0, got}, 32'h0);
        u_pcr_host_model.open_interface(got);
        check("open ack", {31'h0, got}, 32'h1);
        u_pcr_host_model.access(1'b0, PCR_ADDR_POWER, 32'h0, got, rd);
        check("refused write", rd, 32'h0);
        for (int i = 0; i < 13; i++) begin
            u_pcr_host_model.access(1'b1, rows[i].addr, rows[i].data, got, rd);
            check("write ack", {31'h0, got}, 32'h1);
            settle();
            check("pins", obs(), {15'h0, rows[i].pins});
            u_pcr_host_model.access(1'b0, rows[i].addr, 32'h0, got, rd);
            check("readback", rd, rows[i].rback);
        end
        // Software-style sequences: bus off, usb adaptive, rom debug mode
        {usb_req, io_req} = 2'b11;
        settle();
        check("adaptive clocks", obs() & 32'h1f, 32'h18);
        check("panel off", {8'h0, pd_pin}, 32'h0);
        check("iobus out off", {16'h0, io_op}, 32'h0);
        check("iobus in off", {16'h0, io_ic}, 32'h0);
        check("rom idle", {8'h0, ra_pin}, 32'h0);
        u_pcr_host_model.access(1'b1, PCR_ADDR_POWER, 32'h0000_0300, got, rd);
        rom_acc = 1'b1;
        settle();
        check("panel on", {8'h0, pd_pin}, 32'h005a5a5a);
        check("iobus out on", {16'h0, io_op}, 32'h3c3c);
        check("iobus in on", {16'h0, io_ic}, 32'hc3c3);
        check("rom access", {8'h0, ra_pin}, 32'h123456);
        @(negedge clk_sys);
        rom_acc = 1'b0;
        u_pcr_host_model.access(1'b1, PCR_ADDR_ROM, 32'h0000_0001, got, rd);
        settle();
        check("rom always", {8'h0, ra_pin}, 32'h123456);
        // Fill every register, then reset in mid-run
        @(negedge clk_sys);
        {usb_req, io_req} = 2'b00;
        for (int i = 0; i < 5; i++)
            u_pcr_host_model.access(1'b1, addrs[i], 32'hffff_ffff, got, rd);
        // Enabled port power must follow the controller, not the enable alone
        usb_core = 1'b0;
        settle();
        check("usb core low", {31'h0, usb_out}, 32'h0);
        @(negedge clk_sys);
        reset = 1'b1;
        settle();
        check("reset pins", obs(), 32'h1900);
        @(negedge clk_sys);
        reset = 1'b0;
        u_pcr_host_model.access(1'b0, PCR_ADDR_POWER, 32'h0, got, rd);
        check("enable cleared", {31'h0, got}, 32'h0);
        u_pcr_host_model.open_interface(got);
        for (int i = 0; i < 5; i++) begin
            u_pcr_host_model.access(1'b0, addrs[i], 32'h0, got, rd);
            check("reset value", rd, (i == 3) ? 32'h1 : 32'h0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
